// >>> hw/vip_consts.svh
// Behaviour
// - 38 vectored sources across five kinds.
// - Nine maskable event sources.
// - Global plus individual enable gate events.
// - Three-bit priority field per event.
// - Field zero means never serviced.
// - Nonzero field maps to eight plus value.
// - Equal priority ties go to lower rank.
// - Four-byte event vectors from 0080, ranks upward.
// - Fields in bits 2-0 and 6-4.
// - Hardware traps vector from 0004, rank one.
// - Sixteen instruction traps vector into 0040-007F.
// - Seven software interrupts, fixed priority, from 0100.
// - Reset release raises rank zero exception, vector 0000.
// - Vectors are 16-bit values.
// - Boot vector when forced or status nonzero.
// - Idle stops core, enabled interrupt wakes.
// - Power-down ends only by reset or external input.
// - Power-down wake needs enabled level-sensitive input.
`ifndef VIP_CONSTS_SVH
`define VIP_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define VIP_OFF_EN_LO   8'h00
`define VIP_OFF_EN_HI   8'h01
`define VIP_OFF_PRIO0   8'h02
`define VIP_OFF_PRIO5   8'h07
`define VIP_OFF_SWREQ   8'h08
`define VIP_OFF_SWEN    8'h09
`define VIP_OFF_EXTCFG  8'h0A
`define VIP_OFF_PWR     8'h0B
`define VIP_OFF_STAT    8'h0C
`define VIP_OFF_VECLO   8'h0D
`define VIP_OFF_VECHI   8'h0E

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define VIP_BIT_GLOBAL  7
`define VIP_FLD_LO_MSB  2
`define VIP_FLD_HI_LSB  4
`define VIP_RST_REG     8'h00

// ----------------------------------------------------------------
// Vector table
// ----------------------------------------------------------------
`define VIP_VEC_RESET   16'h0000
`define VIP_VEC_HWTRAP  16'h0004
`define VIP_VEC_TRAP    16'h0040
`define VIP_VEC_EVENT   16'h0080
`define VIP_VEC_SOFT    16'h0100
`define VIP_PRIO_EXC    4'hF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define VIP_CLK_MHZ     200
`define VIP_RST_MIN_US  10
`define VIP_RST_MIN_CYC (`VIP_RST_MIN_US * `VIP_CLK_MHZ)

`endif

// >>> hw/vip_pkg.sv
package vip_pkg;

  // Register port request from software.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } vip_bus_t;

  // Request presented to the core.
  typedef struct packed {
    logic        req;
    logic [3:0]  prio;
    logic [15:0] vector;
  } vip_arb_t;

  // Power state, one-hot.
  typedef enum logic [2:0] {
    VIP_RUN   = 3'b001,
    VIP_IDLE  = 3'b010,
    VIP_PDOWN = 3'b100
  } vip_pwr_t;

endpackage

// >>> hw/vip_ctrl.sv
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "vip_consts.svh"

module vip_ctrl
  import vip_pkg::*;
#(
  parameter int N_EVENT = 9,
  parameter int N_SOFT  = 7,
  parameter int N_HWTRP = 5
) (
  input  wire logic              i_mclk,
  input  wire logic              i_resetn,
  input  wire vip_bus_t          i_bus,
  output      logic [7:0]        o_rdata,
  input  wire logic [N_EVENT-1:0] i_event_flag,
  input  wire logic [1:0]        i_ext_pin_n,
  input  wire logic [N_HWTRP-1:0] i_hw_trap,
  input  wire logic              i_trap_req,
  input  wire logic [3:0]        i_trap_num,
  input  wire logic [3:0]        i_core_prio,
  input  wire logic              i_ack,
  input  wire logic              i_boot_force,
  input  wire logic [7:0]        i_flash_status,
  input  wire logic [15:0]       i_boot_vector,
  output      vip_arb_t          o_irq,
  output      logic              o_core_run,
  output      logic              o_osc_stop
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Zero keeps a source silent; any other value sits above eight.
  function automatic logic [3:0] eff_prio(input logic [2:0] fld);
    eff_prio = (fld == 3'h0) ? 4'h0 : {1'b1, fld};
  endfunction

  // Four-byte slot arithmetic for every table region.
  function automatic logic [15:0] slot(input logic [15:0] base,
                                      input logic [4:0]  idx);
    slot = base + {9'h000, idx, 2'b00};
  endfunction

  // Event vectors skip the hole between timer 2 and serial port 0.
  function automatic logic [4:0] ev_slot(input int ev);
    ev_slot = (ev < 5) ? 5'(ev) : 5'(ev + 3);
  endfunction

  // ----------------------------------------------------------------
  // Software visible registers
  // ----------------------------------------------------------------
  logic [7:0] enable_reg_low;
  logic [7:0] enable_reg_high;
  logic [7:0] priority_field_reg [0:5];
  logic [7:0] soft_request;
  logic [7:0] soft_enable;
  logic [1:0] ext_level_mode;
  vip_pwr_t   pwr_state;
  vip_pwr_t   next_pwr;

  logic wr_en_lo;
  logic wr_en_hi;
  logic wr_swreq;
  logic wr_swen;
  logic wr_extcfg;
  logic wr_pwr;

  assign wr_en_lo  = i_bus.we && (i_bus.addr == `VIP_OFF_EN_LO);
  assign wr_en_hi  = i_bus.we && (i_bus.addr == `VIP_OFF_EN_HI);
  assign wr_swreq  = i_bus.we && (i_bus.addr == `VIP_OFF_SWREQ);
  assign wr_swen   = i_bus.we && (i_bus.addr == `VIP_OFF_SWEN);
  assign wr_extcfg = i_bus.we && (i_bus.addr == `VIP_OFF_EXTCFG);
  assign wr_pwr    = i_bus.we && (i_bus.addr == `VIP_OFF_PWR);

  // Enable registers; the global bit lives in the low register.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      enable_reg_low  <= `VIP_RST_REG;
      enable_reg_high <= `VIP_RST_REG;
    end else begin
      if (wr_en_lo)
        enable_reg_low <= i_bus.wdata;
      if (wr_en_hi)
        enable_reg_high <= {4'h0, i_bus.wdata[3:0]};
    end
  end

  // Priority registers keep only the two three-bit fields.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      for (int r = 0; r < 6; r++)
        priority_field_reg[r] <= `VIP_RST_REG;
    end else if (i_bus.we && i_bus.addr >= `VIP_OFF_PRIO0 &&
                 i_bus.addr <= `VIP_OFF_PRIO5) begin
      priority_field_reg[3'(i_bus.addr - `VIP_OFF_PRIO0)] <=
        {1'b0, i_bus.wdata[6:4], 1'b0, i_bus.wdata[2:0]};
    end
  end

  // Software requests are set and cleared only by software.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      soft_request <= `VIP_RST_REG;
      soft_enable  <= `VIP_RST_REG;
    end else begin
      if (wr_swreq)
        soft_request <= {i_bus.wdata[7:1], 1'b0};
      if (wr_swen)
        soft_enable <= {i_bus.wdata[7:1], 1'b0};
    end
  end

  // External input trigger type; only level inputs may end power-down.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn)
      ext_level_mode <= 2'h0;
    else if (wr_extcfg)
      ext_level_mode <= i_bus.wdata[1:0];
  end

  // ----------------------------------------------------------------
  // Source gating
  // ----------------------------------------------------------------
  logic [N_EVENT-1:0] ev_enable;
  logic [3:0]         ev_prio [0:N_EVENT-1];

  // Individual enables: five in the low register, four in the high.
  assign ev_enable = {enable_reg_high[3:0], enable_reg_low[4:0]};

  // Field placement: pairs in registers 0, 1, 4, 5; timer 2 alone in 2.
  always_comb begin
    ev_prio[0] = eff_prio(priority_field_reg[0][2:0]);
    ev_prio[1] = eff_prio(priority_field_reg[0][6:4]);
    ev_prio[2] = eff_prio(priority_field_reg[1][2:0]);
    ev_prio[3] = eff_prio(priority_field_reg[1][6:4]);
    ev_prio[4] = eff_prio(priority_field_reg[2][2:0]);
    ev_prio[5] = eff_prio(priority_field_reg[4][2:0]);
    ev_prio[6] = eff_prio(priority_field_reg[4][6:4]);
    ev_prio[7] = eff_prio(priority_field_reg[5][2:0]);
    ev_prio[8] = eff_prio(priority_field_reg[5][6:4]);
  end

  // ----------------------------------------------------------------
  // Exception and trap pending state
  // ----------------------------------------------------------------
  logic               reset_pend;
  logic [N_HWTRP-1:0] hw_pend;
  logic               trap_pend;
  logic [3:0]         trap_num;
  logic               take_reset;
  logic               take_hw;
  logic               take_trap;
  logic [2:0]         hw_sel;
  logic               use_boot;

  // The reset exception is set pending while the reset input is low and offered once it returns high.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn)
      reset_pend <= 1'b1;
    else if (take_reset)
      reset_pend <= 1'b0;
  end

  // Boot selection follows its inputs through reset and while the reset
  // exception is pending, so the very first offer already carries it.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn || reset_pend)
      use_boot <= i_boot_force || (i_flash_status != 8'h00);
  end

  // A trap that lands in the cycle of its own acknowledge stays pending.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      hw_pend <= '0;
    end else begin
      for (int t = 0; t < N_HWTRP; t++)
        if (i_hw_trap[t])
          hw_pend[t] <= 1'b1;
        else if (take_hw && hw_sel == 3'(t))
          hw_pend[t] <= 1'b0;
    end
  end

  // One instruction trap at a time; the core cannot issue two at once.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      trap_pend <= 1'b0;
      trap_num  <= 4'h0;
    end else if (i_trap_req) begin
      trap_pend <= 1'b1;
      trap_num  <= i_trap_num;
    end else if (take_trap) begin
      trap_pend <= 1'b0;
    end
  end

  // Lowest numbered hardware trap goes first within rank one.
  always_comb begin
    hw_sel = 3'h0;
    for (int t = N_HWTRP - 1; t >= 0; t--)
      if (hw_pend[t])
        hw_sel = 3'(t);
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  vip_arb_t   next_irq;
  logic       ev_win;
  logic [3:0] best_prio;
  logic [15:0] best_vec;

  // Events then software requests, scanned in rank order; a later
  // candidate wins only on a strictly higher level.
  always_comb begin
    best_prio = i_core_prio;
    best_vec  = 16'h0000;
    ev_win    = 1'b0;
    for (int e = 0; e < N_EVENT; e++) begin
      if (i_event_flag[e] && ev_enable[e] &&
          enable_reg_low[`VIP_BIT_GLOBAL] &&
          ev_prio[e] > best_prio) begin
        best_prio = ev_prio[e];
        best_vec  = slot(`VIP_VEC_EVENT, ev_slot(e));
        ev_win    = 1'b1;
      end
    end
    for (int s = 1; s <= N_SOFT; s++) begin
      if (soft_request[s] && soft_enable[s] &&
          4'(s) > best_prio) begin
        best_prio = 4'(s);
        best_vec  = slot(`VIP_VEC_SOFT, 5'(s - 1));
        ev_win    = 1'b1;
      end
    end
  end

  // Exceptions outrank everything and ignore the core's level.
  // An acknowledge clears an exception only while that one is on show.
  always_comb begin
    take_reset    = 1'b0;
    take_hw       = 1'b0;
    take_trap     = 1'b0;
    next_irq.req  = 1'b1;
    next_irq.prio = `VIP_PRIO_EXC;
    if (reset_pend) begin
      next_irq.vector = use_boot ? i_boot_vector : `VIP_VEC_RESET;
      take_reset      = i_ack && o_irq.req && (o_irq.vector == next_irq.vector);
    end else if (|hw_pend) begin
      next_irq.vector = slot(`VIP_VEC_HWTRAP, {2'b00, hw_sel});
      take_hw         = i_ack && o_irq.req && (o_irq.vector == next_irq.vector);
    end else if (trap_pend) begin
      next_irq.vector = slot(`VIP_VEC_TRAP, {1'b0, trap_num});
      take_trap       = i_ack && o_irq.req && (o_irq.vector == next_irq.vector);
    end else begin
      next_irq.req    = ev_win;
      next_irq.prio   = ev_win ? best_prio : 4'h0;
      next_irq.vector = best_vec;
    end
  end

  // The acknowledge blanks one cycle so a taken exception is never seen twice.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_irq <= '0;
    end else begin
      o_irq <= '{next_irq.req && !i_ack, next_irq.prio, next_irq.vector};
    end
  end

  // ----------------------------------------------------------------
  // Power reduction
  // ----------------------------------------------------------------
  logic       pd_wake;
  logic [1:0] ext_wake;

  // Only an enabled, level-sensitive external input low can wake.
  assign ext_wake = ~i_ext_pin_n & ext_level_mode &
                    {enable_reg_low[2], enable_reg_low[0]};
  assign pd_wake  = |ext_wake && enable_reg_low[`VIP_BIT_GLOBAL];

  // Mode entry by software; idle leaves on any forwarded request,
  // power-down only on the external level. Reset also ends both.
  always_comb begin
    next_pwr = pwr_state;
    unique case (pwr_state)
      VIP_RUN: begin
        if (wr_pwr && i_bus.wdata[1])
          next_pwr = VIP_PDOWN;
        else if (wr_pwr && i_bus.wdata[0])
          next_pwr = VIP_IDLE;
      end
      VIP_IDLE: begin
        if (next_irq.req)
          next_pwr = VIP_RUN;
      end
      VIP_PDOWN: begin
        if (pd_wake)
          next_pwr = VIP_RUN;
      end
      default: next_pwr = VIP_RUN;
    endcase
  end

  // A level input is needed because the clock is gone in power-down and
  // the wake condition must still be present when it returns.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      pwr_state  <= VIP_RUN;
      o_core_run <= 1'b1;
      o_osc_stop <= 1'b0;
    end else begin
      pwr_state  <= next_pwr;
      o_core_run <= (next_pwr == VIP_RUN);
      o_osc_stop <= (next_pwr == VIP_PDOWN);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  // Unmapped reads return zero; data is valid only in the next cycle.
  always_comb begin
    next_rdata = 8'h00;
    if (i_bus.re) begin
      unique case (i_bus.addr)
        `VIP_OFF_EN_LO:  next_rdata = enable_reg_low;
        `VIP_OFF_EN_HI:  next_rdata = enable_reg_high;
        `VIP_OFF_SWREQ:  next_rdata = soft_request;
        `VIP_OFF_SWEN:   next_rdata = soft_enable;
        `VIP_OFF_EXTCFG: next_rdata = {6'h00, ext_level_mode};
        `VIP_OFF_PWR:    next_rdata = {5'h00, pwr_state};
        `VIP_OFF_STAT:   next_rdata = {o_irq.req, reset_pend,
                                       trap_pend, |hw_pend, o_irq.prio};
        `VIP_OFF_VECLO:  next_rdata = o_irq.vector[7:0];
        `VIP_OFF_VECHI:  next_rdata = o_irq.vector[15:8];
        default: begin
          if (i_bus.addr >= `VIP_OFF_PRIO0 && i_bus.addr <= `VIP_OFF_PRIO5)
            next_rdata = priority_field_reg[3'(i_bus.addr - `VIP_OFF_PRIO0)];
        end
      endcase
    end
  end

  // Read data stands for exactly one cycle.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn)
      o_rdata <= 8'h00;
    else
      o_rdata <= next_rdata;
  end

endmodule // vip_ctrl

// >>> sim/vip_chk.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module vip_chk
  import vip_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_resetn,
  input wire vip_bus_t    i_bus,
  input wire logic [7:0]  o_rdata,
  input wire logic [1:0]  i_ext_pin_n,
  input wire logic [3:0]  i_core_prio,
  input wire logic        i_ack,
  input wire logic        i_boot_force,
  input wire logic [7:0]  i_flash_status,
  input wire logic [15:0] i_boot_vector,
  input wire vip_arb_t    o_irq,
  input wire logic        o_core_run,
  input wire logic        o_osc_stop
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  // Power-control writes that start a low-power state.
  sequence pd_write;
    i_bus.we && i_bus.addr == 8'h0B && i_bus.wdata[1];
  endsequence
  sequence idle_write;
    i_bus.we && i_bus.addr == 8'h0B && i_bus.wdata[1:0] == 2'b01;
  endsequence

  reset_entry_a: assert property ($rose(i_resetn) |-> ##[1:2] o_irq.req && o_irq.prio == 4'hF &&
    o_irq.vector == ((i_boot_force || i_flash_status != 8'h00) ? i_boot_vector : 16'h0000))
    else $error("reset exception not offered correctly");
  slot_align_a: assert property (o_irq.req |-> o_irq.vector[1:0] == 2'b00 && o_irq.prio != 4'h0 && o_irq.prio != 4'h8)
    else $error("offered slot or level is impossible");
  soft_vector_a: assert property (o_irq.req && o_irq.prio inside {[4'h1:4'h7]} |->
    o_irq.vector == 16'h00FC + {10'h000, o_irq.prio, 2'b00}) else $error("software vector wrong");
  event_vector_a: assert property (o_irq.req && o_irq.prio inside {[4'h9:4'hE]} |->
    o_irq.vector inside {[16'h0080:16'h00AF]}) else $error("event vector out of range");
  above_core_a: assert property (o_irq.req && o_irq.prio != 4'hF && o_irq.vector >= 16'h0080 |->
    o_irq.prio > $past(i_core_prio)) else $error("request not above core level");
  ack_drop_a: assert property (o_irq.req && i_ack |=> !o_irq.req)
    else $error("request kept after acknowledge");
  rdata_idle_a: assert property (!i_bus.re |=> o_rdata == 8'h00)
    else $error("read data without a read");
  pd_enter_a: assert property (pd_write |=> o_osc_stop && !o_core_run)
    else $error("power-down not entered");
  idle_enter_a: assert property (idle_write |=> !o_osc_stop && (!o_core_run || o_irq.req))
    else $error("idle not entered");
  idle_wake_a: assert property (o_irq.req && !o_osc_stop |-> ##[0:1] o_core_run)
    else $error("offered request did not wake core");
  pd_exit_a: assert property ($fell(o_osc_stop) |-> !(&$past(i_ext_pin_n)))
    else $error("power-down left without external pin");
endmodule // vip_chk

bind vip_ctrl vip_chk u_vip_chk (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_ext_pin_n(i_ext_pin_n), .i_core_prio(i_core_prio), .i_ack(i_ack), .i_boot_force(i_boot_force),
  .i_flash_status(i_flash_status), .i_boot_vector(i_boot_vector), .o_irq(o_irq),
  .o_core_run(o_core_run), .o_osc_stop(o_osc_stop));

// >>> sim/vip_core_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Core side that takes offered requests
// ----------------------------------------
module vip_core_model
  import vip_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_ack_on,
  input  wire logic [1:0] i_delay,
  input  wire vip_arb_t   i_irq,
  output      logic       o_ack,
  output      vip_arb_t   o_taken,
  output      logic       o_took
);
  logic [1:0] wait_cnt;
  logic [1:0] gap;

  // Record what the controller showed at the edge that took the acknowledge.
  always_ff @(posedge i_mclk) begin
    o_took <= o_ack && i_irq.req;
    if (o_ack && i_irq.req) begin
      o_taken <= i_irq;
    end
  end

  // Acknowledge after a chosen delay, then hold off two cycles so that a
  // stale offer is never taken twice.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_ack    <= 1'b0;
      wait_cnt <= 2'd0;
      gap      <= 2'd0;
    end else if (o_ack) begin
      o_ack <= 1'b0;
      gap   <= 2'd2;
    end else if (gap != 2'd0) begin
      gap <= gap - 2'd1;
    end else if (i_ack_on && i_irq.req && wait_cnt == i_delay) begin
      o_ack    <= 1'b1;
      wait_cnt <= 2'd0;
    end else if (i_ack_on && i_irq.req) begin
      wait_cnt <= wait_cnt + 2'd1;
    end
  end
endmodule // vip_core_model

// >>> sim/test_vectored_interrupt_priority.sv
`timescale 1ns/10ps
`include "vip_consts.svh"
// ----------------------------------------
// Controller testbench
// ----------------------------------------
module test_vectored_interrupt_priority
  import vip_pkg::*;
;
  localparam logic [8:0] FHI       = 9'b101001010;
  localparam int         PA   [9]  = '{2, 2, 3, 3, 4, 6, 6, 7, 7};
  localparam logic [7:0] EVEC [9]  = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'hA0, 8'hA4, 8'hA8, 8'hAC};
  localparam logic [7:0] MSK  [10] = '{8'hFF, 8'h0F, 8'h77, 8'h77, 8'h77, 8'h77, 8'h77, 8'h77, 8'hFE, 8'hFE};

  logic        i_mclk   = 1'b0;
  logic        i_resetn = 1'b0;
  vip_bus_t    bus      = '0;
  logic [8:0]  ev       = '0;
  logic [1:0]  pin_n    = 2'b11;
  logic [1:0]  dly      = 2'd0;
  logic [4:0]  hw       = '0;
  logic        treq     = 1'b0;
  logic        bforce   = 1'b0;
  logic        ack_on   = 1'b1;
  logic [3:0]  tnum     = '0;
  logic [3:0]  cprio    = '0;
  logic [7:0]  fstat    = '0;
  logic [15:0] bvec     = '0;
  logic [7:0]  sh [16]  = '{default: 8'h00};
  logic [7:0]  rdata, d;
  logic        ack, run, osc, took;
  vip_arb_t    irq, taken, e;
  int          errors, cmp_count;

  // 200 MHz clock.
  always #2.5 i_mclk = ~i_mclk;

  vip_ctrl u_vip_ctrl (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_bus(bus), .o_rdata(rdata), .i_event_flag(ev),
    .i_ext_pin_n(pin_n), .i_hw_trap(hw), .i_trap_req(treq), .i_trap_num(tnum), .i_core_prio(cprio), .i_ack(ack),
    .i_boot_force(bforce), .i_flash_status(fstat), .i_boot_vector(bvec), .o_irq(irq), .o_core_run(run),
    .o_osc_stop(osc));
  vip_core_model u_vip_core_model (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ack_on(ack_on), .i_delay(dly),
    .i_irq(irq), .o_ack(ack), .o_taken(taken), .o_took(took));

  // Bus and comparison helpers; each bus task starts and ends on a rising edge.
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge i_mclk);
    bus <= '0;
    if (a < 8'h10) sh[a[3:0]] = v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_mclk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_mclk);
    bus <= '0;
    @(posedge i_mclk);
    v = rdata;
  endtask
  task automatic wait_took();
    int n;
    n = 0;
    while (!took && n < 60) begin
      @(posedge i_mclk);
      n++;
    end
    check(took, 1'b1);
  endtask

  // Reference arbitration; a strict compare keeps the lower rank on a tie.
  function automatic vip_arb_t exp_arb();
    vip_arb_t   r;
    logic [8:0] en;
    logic [2:0] f;
    r  = '0;
    en = {sh[1][3:0], sh[0][4:0]};
    for (int i = 0; i < 9; i++) begin
      f = FHI[i] ? sh[PA[i]][6:4] : sh[PA[i]][2:0];
      if (ev[i] && en[i] && sh[0][7] && f != 0 && 8 + f > cprio && 8 + f > r.prio) r = '{1'b1, 4'(8 + f), {8'h00, EVEC[i]}};
    end
    for (int k = 1; k < 8; k++)
      if (sh[8][k] && sh[9][k] && k > cprio && k > r.prio) r = '{1'b1, 4'(k), 16'(252 + 4 * k)};
    return r;
  endfunction

  task summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // The whole run takes a few thousand cycles; this limit leaves ample room.
  initial begin
    #200000;
    errors++;
    summarize();
  end

  initial begin
    void'($urandom(68946));
    tick(10);
    i_resetn <= 1'b1;
    wait_took();
    check(taken.vector, 16'h0000);
    for (int a = 0; a < 10; a++) begin
      rd(8'(a), d);
      check(d, 8'h00);
    end
    wr(8'h20, 8'h5A);
    rd(8'h20, d);
    check(d, 8'h00);
    $display("test reset finished");
    for (int it = 0; it < 40; it++) begin
      @(posedge i_mclk);
      ack_on <= 1'b0;
      ev     <= 9'($urandom);
      cprio  <= 4'($urandom % 11);
      dly    <= 2'($urandom);
      for (int a = 0; a < 10; a++) wr(8'(a), (a < 2 && it % 4 != 0) ? 8'hFF : 8'($urandom));
      for (int a = 0; a < 10; a++) begin
        rd(8'(a), d);
        check(d, sh[a] & MSK[a]);
      end
      e = exp_arb();
      check(irq.req, e.req);
      rd(8'h0C, d);
      check(d, {e.req, 3'b000, e.prio});
      rd(8'h0D, d);
      check(d, e.vector[7:0]);
      rd(8'h0E, d);
      check(d, e.vector[15:8]);
      if (e.req) begin
        check({irq.prio, irq.vector}, {e.prio, e.vector});
        @(posedge i_mclk);
        ack_on <= 1'b1;
        wait_took();
        check(taken.vector, e.vector);
      end
    end
    $display("test arbitration finished");
    @(posedge i_mclk);
    ev <= '0;
    wr(8'h08, 8'h00);
    for (int t = 0; t < 21; t++) begin
      @(posedge i_mclk);
      hw     <= 5'(t < 5 ? 1 << t : 0);
      treq   <= (t >= 5);
      tnum   <= 4'(t - 5);
      ack_on <= 1'b1;
      @(posedge i_mclk);
      hw   <= '0;
      treq <= 1'b0;
      wait_took();
      // Hardware traps sit from 0004 upward, instruction traps from 0040 upward.
      check({taken.prio, taken.vector}, {4'hF, 16'(t < 5 ? 4 + 4 * t : 44 + 4 * t)});
    end
    $display("test traps finished");
    @(posedge i_mclk);
    ack_on <= 1'b0;
    cprio  <= 4'h0;
    wr(8'h00, 8'h83);
    wr(8'h02, 8'h11);
    wr(8'h0A, 8'h01);
    wr(8'h0B, 8'h01);
    tick(2);
    check({run, osc}, 2'b00);
    rd(8'h0B, d);
    check(d, 8'h02);
    @(posedge i_mclk);
    ev <= 9'h001;
    tick(3);
    check({run, irq.vector}, {1'b1, 16'h0080});
    @(posedge i_mclk);
    ev <= '0;
    wr(8'h0B, 8'h02);
    tick(2);
    check({run, osc}, 2'b01);
    // An enabled timer event and a pin that is neither enabled nor level mode must not wake it.
    @(posedge i_mclk);
    ev    <= 9'h002;
    pin_n <= 2'b01;
    tick(4);
    check(osc, 1'b1);
    @(posedge i_mclk);
    pin_n <= 2'b10;
    tick(4);
    check({run, osc}, 2'b10);
    $display("test power finished");
    for (int b = 0; b < 2; b++) begin
      @(posedge i_mclk);
      i_resetn <= 1'b0;
      ev       <= '0;
      pin_n    <= 2'b11;
      ack_on   <= 1'b1;
      bforce   <= (b == 0);
      fstat    <= 8'(b);
      bvec     <= 16'($urandom) & 16'hFFFC;
      tick(`VIP_RST_MIN_CYC);
      i_resetn <= 1'b1;
      wait_took();
      check(taken.vector, bvec);
    end
    $display("test boot finished");
    summarize();
  end
endmodule // test_vectored_interrupt_priority
